/* logic/sbc_mode_consts.svh */
`ifndef SBC_MODE_CONSTS_SVH
`define SBC_MODE_CONSTS_SVH

// Clock rate in MHz; the microsecond timings below are converted to cycles with it.
`define SBC_CLOCK_MHZ      20

// Reset output pulse widths in microseconds.
`define SBC_RESET_LONG_US  4000
`define SBC_RESET_SHORT_US 700

// Sleep-entry timeout and transceiver initialisation time in microseconds.
`define SBC_GOTOSLP_US     1000
`define SBC_INIT_NORM_US   20

// Control pins must be stable this many cycles before a new level is accepted.
`define SBC_DEBOUNCE_CYC   4

// Request byte that asks for a status frame, and data bits per frame.
`define SBC_PORT_REQUEST   8'h55
`define SBC_FRAME_BITS     8

// Reset value of the latched event flags.
`define SBC_FLAGS_RESET    6'h00

`endif

/* logic/sbc_mode_controller.sv */
// Notes on behaviour
// - NORMAL: regulator on, transceiver after init, watchdog.
// - NORMAL clears all pending wake-up flags.
// - STANDBY to NORMAL on enable rise, standby low.
// - PORT to NORMAL on standby fall, enable high.
// - STANDBY/sleep-entry: regulator on, wake detect, receive low on wake.
// - RESET exits to STANDBY with valid CRC.
// - NORMAL to STANDBY on enable fall, standby low.
// - PORT to STANDBY on enable fall.
// - PORT: send status frame after 55h request.
// - Frame bits: flags active low, wake levels.
// - Level bit reads one above threshold.
// - Clear reported flags at stop bit rise.
// - Snapshot at start bit fall; later events kept.
// - Enter PORT from sleep-entry or STANDBY, enable rise.
// - NORMAL to sleep-entry on enable fall, sleep enabled.
// - Sleep-entry to SLEEP after timeout, enable low.
// - SLEEP: all off, reset low, wake detect on.
// - Reset event enters RESET, reset held low.
// - OFF leaves via RESET on power-on detection.
// - Battery undervoltage forces OFF from any mode.
// - RESET exits to CONFIG without CRC, supply ok.
// - Receive pin high after entering PORT.
`include "sbc_mode_consts.svh"

module sbc_mode_controller #(
	parameter int TIMER_W        = 20,
	parameter int PERIOD_W       = 16,
	parameter int RESET_LONG_CYC = `SBC_RESET_LONG_US * `SBC_CLOCK_MHZ,
	parameter int RESET_SHRT_CYC = `SBC_RESET_SHORT_US * `SBC_CLOCK_MHZ,
	parameter int GOTOSLP_CYC    = `SBC_GOTOSLP_US * `SBC_CLOCK_MHZ,
	parameter int INIT_CYC       = `SBC_INIT_NORM_US * `SBC_CLOCK_MHZ
) (
	input  wire logic                  clock,         // 20 MHz system clock
	input  wire logic                  reset,         // Power-on reset, synchronous, high
	input  wire logic                  enPin,         // Enable pin from host
	input  wire logic                  standbyCtrlN,  // Standby control pin, low active
	input  wire logic                  txdPin,        // Transmit pin from host
	input  wire logic                  wakeA,         // Local wake input A level
	input  wire logic                  wakeB,         // Local wake input B level
	input  wire logic                  batteryOk,     // Battery above power-on threshold
	input  wire logic                  busWake,       // Bus wake-up detected, one-cycle pulse
	input  wire logic                  fallbackEvent, // Fallback event, one-cycle pulse
	input  wire logic                  resetEvent,    // Reset event, one-cycle pulse
	input  wire logic                  linRxd,        // Bus receiver data for NORMAL mode
	input  wire sbc_mode_pkg::config_t cfg,           // Stored configuration bits
	output sbc_mode_pkg::supply_t      supply,        // Regulator, transceiver, watchdog enables
	output logic                       resetOutN,     // Reset output, low active
	output logic                       rxdPin,        // Receive pin
	output sbc_mode_pkg::mode_t        mode           // Current operating mode
);

	localparam int                  DEB_CYC   = `SBC_DEBOUNCE_CYC;
	localparam logic [1:0]          DEB_LAST  = 2'(DEB_CYC - 1);
	localparam logic [TIMER_W-1:0]  LONG_LAST = TIMER_W'(RESET_LONG_CYC - 1);
	localparam logic [TIMER_W-1:0]  SHRT_LAST = TIMER_W'(RESET_SHRT_CYC - 1);
	localparam logic [TIMER_W-1:0]  SLP_LAST  = TIMER_W'(GOTOSLP_CYC - 1);
	localparam logic [TIMER_W-1:0]  INIT_LAST = TIMER_W'(INIT_CYC - 1);
	localparam logic [PERIOD_W-1:0] PER_ONE   = PERIOD_W'(1);
	localparam logic [3:0]          LAST_BIT  = 4'(`SBC_FRAME_BITS - 1);
	localparam logic [3:0]          STOP_SLOT = 4'(`SBC_FRAME_BITS);

	if (DEB_CYC < 2 || DEB_CYC > 4) begin : g_bad_debounce
		$error("Debounce count must lie between 2 and 4.");
	end
	if (RESET_LONG_CYC >= 2 ** TIMER_W || RESET_SHRT_CYC >= 2 ** TIMER_W ||
		GOTOSLP_CYC >= 2 ** TIMER_W || INIT_CYC < 1 || RESET_SHRT_CYC < 1) begin : g_bad_timer
		$error("Timer width cannot hold the timing counts.");
	end
	if (PERIOD_W < 4) begin : g_bad_period
		$error("Bit period counter is too narrow.");
	end

	typedef struct packed {
		sbc_mode_pkg::mode_t   mode;
		logic [TIMER_W-1:0]    timer;
		logic                  initDone;
		sbc_mode_pkg::pins_t   s1;
		sbc_mode_pkg::pins_t   s2;
		logic [1:0]            filt;
		logic [1:0]            filtPrev;
		logic [1:0][1:0]       deb;
		logic [1:0]            wakePrev;
		logic [5:0]            flags;
		logic [5:0]            snap;
		sbc_mode_pkg::frame_t  frame;
		logic [3:0]            bitCnt;
		logic [PERIOD_W-1:0]   period;
		logic [PERIOD_W-1:0]   bcnt;
		logic [7:0]            shift;
		logic                  txdPrev;
		sbc_mode_pkg::supply_t sup;
		logic                  resetN;
		logic                  rxd;
	} state_t;

	state_t              q;
	state_t              d;
	sbc_mode_pkg::pins_t pinsIn;
	logic                enRise;
	logic                enFall;
	logic                stbyFall;
	logic                txdFall;
	logic                txdRise;
	logic                batSync;
	logic                override;
	logic                detectOn;
	logic [5:0]          newEv;

	assign pinsIn   = '{en: enPin, standbyN: standbyCtrlN, txd: txdPin,
			wakeA: wakeA, wakeB: wakeB, batteryOk: batteryOk};
	// Only the filtered enable and standby levels reach the mode logic, so a bouncing pin makes one edge.
	assign enRise   = q.filt[0] & ~q.filtPrev[0];
	assign enFall   = ~q.filt[0] & q.filtPrev[0];
	assign stbyFall = ~q.filt[1] & q.filtPrev[1];
	assign txdFall  = ~q.s2.txd & q.txdPrev;
	assign txdRise  = q.s2.txd & ~q.txdPrev;
	assign batSync  = q.s2.batteryOk;
	assign override = ~batSync | (resetEvent & (q.mode != sbc_mode_pkg::MODE_OFF));
	assign detectOn = (q.mode == sbc_mode_pkg::MODE_STANDBY) | (q.mode == sbc_mode_pkg::MODE_SLEEP_ENTRY) |
			(q.mode == sbc_mode_pkg::MODE_SLEEP) | (q.mode == sbc_mode_pkg::MODE_PORT);
	assign newEv    = {fallbackEvent & (q.mode != sbc_mode_pkg::MODE_OFF),
			{~q.s2.wakeB & q.wakePrev[1], q.s2.wakeB & ~q.wakePrev[1]} & {2{cfg.wakeBEnable & detectOn}},
			{~q.s2.wakeA & q.wakePrev[0], q.s2.wakeA & ~q.wakePrev[0]} & {2{cfg.wakeAEnable & detectOn}},
			busWake & cfg.busWakeEnable & detectOn};

	always_comb begin
		logic [5:0]          clearMask;
		logic [1:0]          raw;
		logic [PERIOD_W-1:0] len;
		clearMask = 6'h00;
		raw       = {q.s2.standbyN, q.s2.en};
		len       = q.bcnt + PER_ONE;
		d         = q;
		d.s1      = pinsIn;
		d.s2      = q.s1;
		d.txdPrev = q.s2.txd;
		d.wakePrev = {q.s2.wakeB, q.s2.wakeA};
		d.filtPrev = q.filt;
		for (int i = 0; i < 2; i++) begin
			if (raw[i] == q.filt[i]) begin
				d.deb[i] = 2'h0;
			end else if (q.deb[i] == DEB_LAST) begin
				d.filt[i] = raw[i];
				d.deb[i]  = 2'h0;
			end else begin
				d.deb[i] = q.deb[i] + 2'h1;
			end
		end
		if (q.timer != {TIMER_W{1'b1}}) begin
			d.timer = q.timer + TIMER_W'(1);
		end

		// Mode sequencing; power loss outranks a reset event, which outranks pin requests.
		if (~batSync) begin
			d.mode = sbc_mode_pkg::MODE_OFF;
		end else if (resetEvent && q.mode != sbc_mode_pkg::MODE_OFF) begin
			d.mode = sbc_mode_pkg::MODE_RESET;
		end else begin
			case (q.mode)
				sbc_mode_pkg::MODE_OFF: begin
					d.mode = sbc_mode_pkg::MODE_RESET;
				end
				sbc_mode_pkg::MODE_RESET: begin
					if (q.timer == (cfg.resetShort ? SHRT_LAST : LONG_LAST)) begin
						if (cfg.crcValid) begin
							d.mode = sbc_mode_pkg::MODE_STANDBY;
						end else if (cfg.configSupplyOk) begin
							d.mode = sbc_mode_pkg::MODE_CONFIG;
						end else begin
							d.timer = '0;
						end
					end
				end
				sbc_mode_pkg::MODE_STANDBY: begin
					if (enRise && !q.filt[1]) begin
						d.mode = sbc_mode_pkg::MODE_NORMAL;
					end else if (enRise) begin
						d.mode = sbc_mode_pkg::MODE_PORT;
					end
				end
				sbc_mode_pkg::MODE_NORMAL: begin
					if (enFall && (!q.filt[1] || cfg.sleepDisable)) begin
						d.mode = sbc_mode_pkg::MODE_STANDBY;
					end else if (enFall) begin
						d.mode = sbc_mode_pkg::MODE_SLEEP_ENTRY;
					end
				end
				sbc_mode_pkg::MODE_PORT: begin
					if (enFall) begin
						d.mode = sbc_mode_pkg::MODE_STANDBY;
					end else if (stbyFall && q.filt[0]) begin
						d.mode = sbc_mode_pkg::MODE_NORMAL;
					end
				end
				sbc_mode_pkg::MODE_SLEEP_ENTRY: begin
					if (enRise) begin
						d.mode = sbc_mode_pkg::MODE_PORT;
					end else if (q.timer == SLP_LAST && !q.filt[0]) begin
						d.mode = sbc_mode_pkg::MODE_SLEEP;
					end
				end
				sbc_mode_pkg::MODE_SLEEP: begin
					// A latched wake-up restarts the system through a reset pulse.
					if (|q.flags[4:0]) begin
						d.mode = sbc_mode_pkg::MODE_RESET;
					end
				end
				sbc_mode_pkg::MODE_CONFIG: begin
					d.mode = sbc_mode_pkg::MODE_CONFIG;
				end
				default: begin
					d.mode = sbc_mode_pkg::MODE_OFF;
				end
			endcase
		end
		if (d.mode != q.mode) begin
			d.timer = '0;
		end
		d.initDone = (d.mode == sbc_mode_pkg::MODE_NORMAL) &&
				(q.initDone || (q.mode == sbc_mode_pkg::MODE_NORMAL && q.timer == INIT_LAST));

		// Status frame: the request start bit is timed to learn the host's bit period.
		if (q.mode != sbc_mode_pkg::MODE_PORT || d.mode != sbc_mode_pkg::MODE_PORT) begin
			d.frame = sbc_mode_pkg::FRAME_IDLE;
			d.rxd   = 1'b1;
		end else begin
			case (q.frame)
				sbc_mode_pkg::FRAME_IDLE: begin
					if (txdFall) begin
						d.frame = sbc_mode_pkg::FRAME_MEASURE;
						d.bcnt  = '0;
					end
				end
				sbc_mode_pkg::FRAME_MEASURE: begin
					if (txdRise) begin
						d.period   = len;
						d.bcnt     = len + (len >> 1) - PER_ONE;
						d.shift    = 8'h01;
						d.bitCnt   = 4'h1;
						d.frame    = sbc_mode_pkg::FRAME_RXBITS;
					end else if (q.bcnt[PERIOD_W-1]) begin
						d.frame = sbc_mode_pkg::FRAME_IDLE;
					end else begin
						d.bcnt = len;
					end
				end
				sbc_mode_pkg::FRAME_RXBITS: begin
					if (q.bcnt != '0) begin
						d.bcnt = q.bcnt - PER_ONE;
					end else if (q.bitCnt != STOP_SLOT) begin
						d.shift[q.bitCnt[2:0]] = q.s2.txd;
						d.bitCnt = q.bitCnt + 4'h1;
						d.bcnt   = q.period - PER_ONE;
					end else if (q.s2.txd && q.shift == `SBC_PORT_REQUEST) begin
						// Snapshot taken on the edge that drives the start bit low.
						d.snap  = q.flags;
						d.shift = {~q.flags, q.s2.wakeB, q.s2.wakeA};
						d.rxd   = 1'b0;
						d.bcnt  = q.period - PER_ONE;
						d.frame = sbc_mode_pkg::FRAME_TXSTART;
					end else begin
						d.frame = sbc_mode_pkg::FRAME_IDLE;
					end
				end
				sbc_mode_pkg::FRAME_TXSTART: begin
					if (q.bcnt != '0) begin
						d.bcnt = q.bcnt - PER_ONE;
					end else begin
						d.rxd    = q.shift[0];
						d.shift  = q.shift >> 1;
						d.bitCnt = 4'h0;
						d.bcnt   = q.period - PER_ONE;
						d.frame  = sbc_mode_pkg::FRAME_TXBITS;
					end
				end
				sbc_mode_pkg::FRAME_TXBITS: begin
					if (q.bcnt != '0) begin
						d.bcnt = q.bcnt - PER_ONE;
					end else if (q.bitCnt == LAST_BIT) begin
						d.rxd     = 1'b1;
						clearMask = q.snap;
						d.bcnt    = q.period - PER_ONE;
						d.frame   = sbc_mode_pkg::FRAME_TXSTOP;
					end else begin
						d.rxd    = q.shift[0];
						d.shift  = q.shift >> 1;
						d.bitCnt = q.bitCnt + 4'h1;
						d.bcnt   = q.period - PER_ONE;
					end
				end
				sbc_mode_pkg::FRAME_TXSTOP: begin
					if (q.bcnt != '0) begin
						d.bcnt = q.bcnt - PER_ONE;
					end else begin
						d.frame = sbc_mode_pkg::FRAME_IDLE;
					end
				end
				default: begin
					d.frame = sbc_mode_pkg::FRAME_IDLE;
				end
			endcase
		end

		// A new event in the clearing cycle survives because the set is applied last.
		d.flags = (q.flags & ~clearMask) | newEv;
		if (q.mode == sbc_mode_pkg::MODE_NORMAL) begin
			d.flags[4:0] = 5'h00;
		end
		if (d.mode == sbc_mode_pkg::MODE_OFF) begin
			d.flags = `SBC_FLAGS_RESET;
		end

		d.sup    = '0;
		d.resetN = 1'b1;
		case (d.mode)
			sbc_mode_pkg::MODE_OFF, sbc_mode_pkg::MODE_SLEEP: begin
				d.resetN = 1'b0;
				d.rxd    = 1'b0;
			end
			sbc_mode_pkg::MODE_RESET: begin
				d.sup.regulatorOn = 1'b1;
				d.resetN          = 1'b0;
				d.rxd             = 1'b1;
			end
			sbc_mode_pkg::MODE_STANDBY, sbc_mode_pkg::MODE_SLEEP_ENTRY, sbc_mode_pkg::MODE_PORT: begin
				d.sup.regulatorOn        = 1'b1;
				d.sup.watchdogRun        = cfg.watchdogEnable & ~cfg.watchdogAutoSel;
				d.sup.watchdogAutonomous = cfg.watchdogEnable & cfg.watchdogAutoSel;
				if (d.mode != sbc_mode_pkg::MODE_PORT) begin
					d.rxd = ~|d.flags[4:0];
				end
			end
			sbc_mode_pkg::MODE_NORMAL: begin
				d.sup.regulatorOn   = 1'b1;
				d.sup.transceiverOn = cfg.linEnable & d.initDone;
				d.sup.watchdogRun   = cfg.watchdogEnable;
				d.rxd               = linRxd;
			end
			sbc_mode_pkg::MODE_CONFIG: begin
				d.sup.regulatorOn = 1'b1;
				d.rxd             = 1'b1;
			end
			default: begin
				d.resetN = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			q      <= '0;
			q.mode <= sbc_mode_pkg::MODE_OFF;
		end else begin
			q <= d;
		end
	end

	assign supply    = q.sup;
	assign resetOutN = q.resetN;
	assign rxdPin    = q.rxd;
	assign mode      = q.mode;

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (reset);

	chk_normal_supply: assert property (mode == sbc_mode_pkg::MODE_NORMAL |-> supply.regulatorOn && resetOutN &&
			(supply.transceiverOn == (cfg.linEnable && q.initDone))) else $error("NORMAL supply wrong.");
	chk_normal_clear: assert property (mode == sbc_mode_pkg::MODE_NORMAL && $past(mode) == sbc_mode_pkg::MODE_NORMAL
			|-> q.flags[4:0] == 5'h00) else $error("Wake flags kept in NORMAL.");
	chk_standby_normal: assert property (mode == sbc_mode_pkg::MODE_STANDBY && enRise && !q.filt[1] && !override
			|=> mode == sbc_mode_pkg::MODE_NORMAL) else $error("STANDBY did not go to NORMAL.");
	chk_wake_rxd: assert property (mode == sbc_mode_pkg::MODE_STANDBY && |q.flags[4:0] |-> !rxdPin && supply.regulatorOn
			&& !supply.transceiverOn) else $error("Wake not shown on receive pin.");
	chk_normal_standby: assert property (mode == sbc_mode_pkg::MODE_NORMAL && enFall && cfg.sleepDisable && !override
			|=> mode == sbc_mode_pkg::MODE_STANDBY) else $error("NORMAL did not go to STANDBY.");
	chk_sleep_off: assert property (mode == sbc_mode_pkg::MODE_SLEEP |-> supply == '0 && !resetOutN)
			else $error("SLEEP outputs not off.");
	chk_reset_hold: assert property ($rose(mode == sbc_mode_pkg::MODE_RESET) |-> !resetOutN [*8])
			else $error("Reset output released early.");
	chk_off_entry: assert property (!batSync |=> mode == sbc_mode_pkg::MODE_OFF && !resetOutN)
			else $error("Undervoltage did not force OFF.");
	chk_port_rxd: assert property ($rose(mode == sbc_mode_pkg::MODE_PORT) |-> rxdPin && q.frame == sbc_mode_pkg::FRAME_IDLE)
			else $error("Receive pin not high in PORT.");
	chk_stop_clear: assert property (q.frame == sbc_mode_pkg::FRAME_TXSTOP && $past(q.frame) == sbc_mode_pkg::FRAME_TXBITS
			|-> rxdPin && ((q.flags & $past(q.snap) & ~$past(newEv)) == 6'h00)) else $error("Flags not cleared at stop.");

endmodule : sbc_mode_controller

/* logic/sbc_mode_pkg.sv */
package sbc_mode_pkg;

	typedef enum logic [3:0] {
		MODE_OFF         = 4'h0,
		MODE_RESET       = 4'h1,
		MODE_STANDBY     = 4'h2,
		MODE_NORMAL      = 4'h3,
		MODE_PORT        = 4'h4,
		MODE_SLEEP_ENTRY = 4'h5,
		MODE_SLEEP       = 4'h6,
		MODE_CONFIG      = 4'h7
	} mode_t;

	typedef enum logic [2:0] {
		FRAME_IDLE    = 3'h0,
		FRAME_MEASURE = 3'h1,
		FRAME_RXBITS  = 3'h2,
		FRAME_TXSTART = 3'h3,
		FRAME_TXBITS  = 3'h4,
		FRAME_TXSTOP  = 3'h5
	} frame_t;

	typedef struct packed {
		logic en;
		logic standbyN;
		logic txd;
		logic wakeA;
		logic wakeB;
		logic batteryOk;
	} pins_t;

	typedef struct packed {
		logic sleepDisable;
		logic resetShort;
		logic crcValid;
		logic configSupplyOk;
		logic linEnable;
		logic watchdogEnable;
		logic watchdogAutoSel;
		logic wakeAEnable;
		logic wakeBEnable;
		logic busWakeEnable;
	} config_t;

	typedef struct packed {
		logic regulatorOn;
		logic transceiverOn;
		logic watchdogRun;
		logic watchdogAutonomous;
	} supply_t;

endpackage : sbc_mode_pkg

/* testbench/host_mcu_model.sv */
module host_mcu_model (
	input  wire logic clock,        // Device clock, used only to pace the pins
	input  wire logic rxdPin,       // Receive pin from the device
	output logic      enPin,        // Enable pin
	output logic      standbyCtrlN, // Standby control pin, low active
	output logic      txdPin        // Transmit pin, idle high
);
	timeunit 1ns;
	timeprecision 1ns;

	initial begin
		enPin = 1'b0;
		standbyCtrlN = 1'b0;
		txdPin = 1'b1;
	end

	// Pins move just after a falling edge, so the device never samples them mid-change.
	task automatic setPins(input logic en, input logic stbyN);
		@(negedge clock);
		enPin = en;
		standbyCtrlN = stbyN;
	endtask : setPins

	// Returns once the stop bit has begun, because the answer starts inside that stop bit.
	task automatic sendByte(input logic [7:0] value, input int period);
		logic [9:0] bits;
		bits = {1'b1, value, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(negedge clock);
			txdPin = bits[i];
			if (i < 9) begin
				repeat (period - 1) @(negedge clock);
			end
		end
	endtask : sendByte

	task automatic readFrame(input int period, output logic [7:0] value, output logic ok);
		int n;
		n = 0;
		value = 8'h00;
		while (rxdPin !== 1'b0 && n < 4 * period) begin
			@(negedge clock);
			n++;
		end
		ok = n < 4 * period;
		repeat (period / 2) @(negedge clock);
		for (int i = 0; i < 8; i++) begin
			repeat (period) @(negedge clock);
			value[i] = rxdPin;
		end
		repeat (period) @(negedge clock);
		ok = ok && (rxdPin === 1'b1);
		// A request that starts inside the stop period is ignored, so let that period run out first.
		repeat (period) @(negedge clock);
	endtask : readFrame
endmodule : host_mcu_model

/* testbench/test_sbc_mode_controller.sv */
module test_sbc_mode_controller;
	timeunit 1ns;
	timeprecision 1ns;

	logic                  clock;
	logic                  reset;
	logic                  enPin;
	logic                  standbyCtrlN;
	logic                  txdPin;
	logic                  wakeA;
	logic                  wakeB;
	logic                  batteryOk;
	logic                  busWake;
	logic                  fallbackEvent;
	logic                  resetEvent;
	logic                  linRxd;
	sbc_mode_pkg::config_t cfg;
	sbc_mode_pkg::supply_t supply;
	logic                  resetOutN;
	logic                  rxdPin;
	sbc_mode_pkg::mode_t   mode;
	int                    nErrors = 0;
	int                    checks = 0;
	logic [7:0]            got;
	logic                  ok;
	int                    n;

	sbc_mode_controller #(.RESET_LONG_CYC(40), .RESET_SHRT_CYC(20), .GOTOSLP_CYC(50), .INIT_CYC(10)) DUT (
		.clock(clock), .reset(reset), .enPin(enPin), .standbyCtrlN(standbyCtrlN), .txdPin(txdPin),
		.wakeA(wakeA), .wakeB(wakeB), .batteryOk(batteryOk), .busWake(busWake),
		.fallbackEvent(fallbackEvent), .resetEvent(resetEvent), .linRxd(linRxd), .cfg(cfg),
		.supply(supply), .resetOutN(resetOutN), .rxdPin(rxdPin), .mode(mode)
	);

	host_mcu_model host (
		.clock(clock), .rxdPin(rxdPin), .enPin(enPin), .standbyCtrlN(standbyCtrlN), .txdPin(txdPin)
	);

	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end

	task automatic conclude;
		$display("checks %0d, mismatches %0d", checks, nErrors);
		if (nErrors == 0 && checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : conclude

	task automatic check(input logic [7:0] seen, input logic [7:0] expected, input string what);
		checks++;
		if (seen !== expected) begin
			nErrors++;
			$display("wrong value at %0t: %s saw %h expected %h", $time, what, seen, expected);
		end
	endtask : check

	task automatic waitMode(input sbc_mode_pkg::mode_t m, input int bound, output int cnt);
		cnt = 0;
		while (mode !== m && cnt < bound) begin
			@(negedge clock);
			cnt++;
		end
		check(8'(mode), 8'(m), "mode reached");
		if (mode !== m) begin
			conclude();
		end
	endtask : waitMode

	// Mode answers exactly seven edges after a clean pin change.
	task automatic modeStep(input logic en, input logic stbyN, input sbc_mode_pkg::mode_t from,
			input sbc_mode_pkg::mode_t to);
		host.setPins(en, stbyN);
		repeat (6) @(negedge clock);
		check(8'(mode), 8'(from), "mode before");
		@(negedge clock);
		check(8'(mode), 8'(to), "mode after");
	endtask : modeStep

	task automatic armSleep;
		modeStep(1'b1, 1'b0, sbc_mode_pkg::MODE_STANDBY, sbc_mode_pkg::MODE_NORMAL);
		host.setPins(1'b1, 1'b1);
		repeat (8) @(negedge clock);
		check(8'(mode), 8'(sbc_mode_pkg::MODE_NORMAL), "standby rise ignored");
	endtask : armSleep

	task automatic pulse(input int which);
		@(negedge clock);
		busWake = which == 0;
		fallbackEvent = which == 1;
		resetEvent = which == 2;
		@(negedge clock);
		{busWake, fallbackEvent, resetEvent} = 3'h0;
	endtask : pulse

	task automatic endTest(input string name);
		$display("test %s done, mismatches so far %0d", name, nErrors);
	endtask : endTest

	initial begin
		reset = 1'b1;
		{wakeA, wakeB, busWake, fallbackEvent, resetEvent} = 5'h00;
		batteryOk = 1'b1;
		linRxd = 1'b1;
		cfg = '{default: 1'b1};
		cfg.sleepDisable = 1'b0;
		cfg.resetShort = 1'b0;
		cfg.watchdogAutoSel = 1'b0;
		repeat (10) @(negedge clock);
		reset = 1'b0;
		waitMode(sbc_mode_pkg::MODE_RESET, 10, n);
		check(8'(resetOutN), 8'h00, "reset output in reset");
		waitMode(sbc_mode_pkg::MODE_STANDBY, 60, n);
		check(8'(n >= 38 && n <= 42), 8'h01, "reset width");
		check(8'({supply.regulatorOn, supply.transceiverOn, resetOutN, rxdPin, supply.watchdogRun,
				supply.watchdogAutonomous}), 8'h2e, "standby outputs");
		endTest("boot");

		modeStep(1'b1, 1'b0, sbc_mode_pkg::MODE_STANDBY, sbc_mode_pkg::MODE_NORMAL);
		check(8'({supply.regulatorOn, supply.transceiverOn}), 8'h02, "transceiver waits");
		repeat (12) @(negedge clock);
		check(8'({supply.regulatorOn, supply.transceiverOn, supply.watchdogRun}), 8'h07, "normal supply");
		linRxd = 1'b0;
		repeat (2) @(negedge clock);
		check(8'(rxdPin), 8'h00, "bus data on receive pin");
		linRxd = 1'b1;
		modeStep(1'b0, 1'b0, sbc_mode_pkg::MODE_NORMAL, sbc_mode_pkg::MODE_STANDBY);
		endTest("normal");

		modeStep(1'b1, 1'b1, sbc_mode_pkg::MODE_STANDBY, sbc_mode_pkg::MODE_PORT);
		check(8'(rxdPin), 8'h01, "port idle high");
		@(negedge clock);
		wakeA = 1'b1;
		pulse(0);
		pulse(1);
		repeat (5) @(negedge clock);
		host.sendByte(8'h55, 8);
		host.readFrame(8, got, ok);
		check(8'(ok), 8'h01, "frame framing");
		check(got, 8'h71, "first frame");
		host.sendByte(8'h55, 12);
		host.readFrame(12, got, ok);
		check(8'(ok), 8'h01, "second frame framing");
		check(got, 8'hfd, "flags cleared");
		// Bit 0 is high so the start bit is measured correctly and only the value is wrong.
		host.sendByte(8'h57, 8);
		host.readFrame(8, got, ok);
		check(8'(ok), 8'h00, "other byte refused");
		modeStep(1'b0, 1'b1, sbc_mode_pkg::MODE_PORT, sbc_mode_pkg::MODE_STANDBY);
		endTest("port frame");

		@(negedge clock);
		wakeB = 1'b1;
		repeat (5) @(negedge clock);
		check(8'(rxdPin), 8'h00, "wake holds receive low");
		modeStep(1'b1, 1'b1, sbc_mode_pkg::MODE_STANDBY, sbc_mode_pkg::MODE_PORT);
		modeStep(1'b1, 1'b0, sbc_mode_pkg::MODE_PORT, sbc_mode_pkg::MODE_NORMAL);
		modeStep(1'b0, 1'b0, sbc_mode_pkg::MODE_NORMAL, sbc_mode_pkg::MODE_STANDBY);
		check(8'(rxdPin), 8'h01, "wake flags cleared");
		endTest("wake clear");

		armSleep();
		modeStep(1'b0, 1'b1, sbc_mode_pkg::MODE_NORMAL, sbc_mode_pkg::MODE_SLEEP_ENTRY);
		check(8'({supply.regulatorOn, supply.transceiverOn}), 8'h02, "sleep entry supply");
		waitMode(sbc_mode_pkg::MODE_SLEEP, 70, n);
		check(8'(n >= 45), 8'h01, "sleep timeout length");
		@(negedge clock);
		check(8'({supply.regulatorOn, supply.transceiverOn, supply.watchdogRun, resetOutN}), 8'h00, "sleep");
		pulse(0);
		waitMode(sbc_mode_pkg::MODE_RESET, 10, n);
		waitMode(sbc_mode_pkg::MODE_STANDBY, 60, n);
		endTest("sleep");

		cfg.sleepDisable = 1'b1;
		armSleep();
		modeStep(1'b0, 1'b1, sbc_mode_pkg::MODE_NORMAL, sbc_mode_pkg::MODE_STANDBY);
		cfg.sleepDisable = 1'b0;
		armSleep();
		modeStep(1'b0, 1'b1, sbc_mode_pkg::MODE_NORMAL, sbc_mode_pkg::MODE_SLEEP_ENTRY);
		modeStep(1'b1, 1'b1, sbc_mode_pkg::MODE_SLEEP_ENTRY, sbc_mode_pkg::MODE_PORT);
		endTest("sleep disable");

		pulse(2);
		waitMode(sbc_mode_pkg::MODE_RESET, 3, n);
		check(8'(resetOutN), 8'h00, "reset event output");
		waitMode(sbc_mode_pkg::MODE_STANDBY, 60, n);
		cfg.watchdogAutoSel = 1'b1;
		@(negedge clock);
		check(8'({supply.watchdogRun, supply.watchdogAutonomous}), 8'h01, "autonomous watchdog");
		batteryOk = 1'b0;
		waitMode(sbc_mode_pkg::MODE_OFF, 5, n);
		@(negedge clock);
		check(8'({supply.regulatorOn, resetOutN}), 8'h00, "off outputs");
		cfg.crcValid = 1'b0;
		batteryOk = 1'b1;
		waitMode(sbc_mode_pkg::MODE_RESET, 10, n);
		waitMode(sbc_mode_pkg::MODE_CONFIG, 60, n);
		endTest("power");
		conclude();
	end
endmodule : test_sbc_mode_controller
